/* hw/pulse_timer_pkg.sv */
// Package with register map, field positions, reset values and types of the pulse timer.
package pulse_timer_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] off_gsc = 8'h00;
  localparam logic [7:0] off_cnth = 8'h04;
  localparam logic [7:0] off_cntl = 8'h08;
  localparam logic [7:0] off_modh = 8'h0C;
  localparam logic [7:0] off_modl = 8'h10;
  localparam logic [7:0] off_csc = 8'h14;
  localparam logic [7:0] off_cval = 8'h18;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int flag_bit = 7;
  localparam int ie_bit = 6;
  localparam int mode_bit = 5;
  localparam int msa_bit = 4;
  localparam int clks_lo = 3;
  localparam int els_lo = 2;
  localparam logic [15:0] cnt_reset = 16'h0000;
  localparam logic [15:0] mod_reset = 16'h0000;
  localparam logic [15:0] cval_reset = 16'h0000;
  localparam logic [15:0] free_top = 16'hFFFF;
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam int sync_stages = 2;
  localparam int ps_width = 3;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    src_none = 2'b00,
    src_bus = 2'b01,
    src_fixed = 2'b10,
    src_ext = 2'b11
  } clk_src_t;
  typedef enum logic {
    st_addr = 1'b0,
    st_data = 1'b1
  } bus_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic write;
  } ahb_req_t;
endpackage : pulse_timer_pkg

/* hw/clk_sync_edge.sv */
// Synchroniser with rising edge detector for the external clock source.
`timescale 1ns/1ps
module clk_sync_edge
  import pulse_timer_pkg::*;
#(
  parameter int stages = sync_stages
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic async_in,
  output logic rise
);
  logic [stages:0] chain;
  // ---------------------------------------------------------------
  // Synchroniser chain
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g <= stages; g++) begin : g_stage
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          chain[g] <= 1'b0;
        end else if (clk_en) begin
          chain[g] <= (g == 0) ? async_in : chain[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate
  assign rise = chain[stages] ^ chain[stages - 1] ? chain[stages - 1] : 1'b0;
  property p_sync_rise;
    @(posedge hclk) disable iff (!hresetn) rise |-> chain[stages - 1] && !chain[stages];
  endproperty
  a_sync_rise: assert property (p_sync_rise) else $error("edge without synchronised rise");
endmodule : clk_sync_edge

/* hw/tick_prescaler.sv */
// Power-of-two prescaler that turns source ticks into counter ticks.
`timescale 1ns/1ps
module tick_prescaler
  import pulse_timer_pkg::*;
#(
  parameter int width = 7
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic src_tick,
  input wire logic [ps_width-1:0] ps,
  output logic tick
);
  logic [width-1:0] div;
  logic [width-1:0] mask;
  assign mask = width'((1 << ps) - 1);
  assign tick = src_tick && ((div & mask) == mask);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div <= '0;
    end else if (clk_en && src_tick) begin
      div <= div + width'(1);
    end
  end
  property p_div_one;
    @(posedge hclk) disable iff (!hresetn) (ps == '0) |-> (tick == src_tick);
  endproperty
  a_div_one: assert property (p_div_one) else $error("divide by one lost a tick");
endmodule : tick_prescaler

/* hw/pulse_timer_module.sv */
// Pulse timer core with AHB-Lite register slave, counter, modulo and one channel.
`timescale 1ns/1ps
module pulse_timer_module
  import pulse_timer_pkg::*;
#(
  parameter int pre_width = 7
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic debug_halt,
  input wire logic fixed_clk_tick,
  input wire logic ext_clk,
  input wire logic capture_in,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic overflow_irq,
  output logic channel_irq
);
  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  bus_state_t state;
  ahb_req_t req;
  logic [7:0] wd;
  assign wd = hwdata[7:0];

  function automatic logic hit(input bus_state_t s, input ahb_req_t r, input logic [7:0] off,
                               input logic wr);
    hit = (s == st_data) && (r.addr == off) && (r.write == wr);
  endfunction : hit

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= st_addr;
      req <= '0;
      hreadyout <= 1'b1;
    end else if (clk_en) begin
      if (state == st_addr && hsel && hready && htrans == htrans_nonseq) begin
        state <= st_data;
        req <= '{addr: haddr[7:0], write: hwrite};
        hreadyout <= 1'b0;
      end else if (state == st_data) begin
        state <= st_addr;
        hreadyout <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else if (clk_en) begin
      hresp <= 1'b0;
    end
  end

  logic w_gsc, w_cnt, w_modh, w_modl, w_csc, w_cval;
  logic r_gsc, r_cnth, r_cntl, r_csc;
  assign w_gsc = hit(state, req, off_gsc, 1'b1);
  assign w_cnt = hit(state, req, off_cnth, 1'b1) || hit(state, req, off_cntl, 1'b1);
  assign w_modh = hit(state, req, off_modh, 1'b1);
  assign w_modl = hit(state, req, off_modl, 1'b1);
  assign w_csc = hit(state, req, off_csc, 1'b1);
  assign w_cval = hit(state, req, off_cval, 1'b1);
  assign r_gsc = hit(state, req, off_gsc, 1'b0);
  assign r_cnth = hit(state, req, off_cnth, 1'b0);
  assign r_cntl = hit(state, req, off_cntl, 1'b0);
  assign r_csc = hit(state, req, off_csc, 1'b0);

  // ---------------------------------------------------------------
  // Global control
  // ---------------------------------------------------------------
  logic toie, center_aligned_select;
  clk_src_t clks;
  logic [ps_width-1:0] ps;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      toie <= 1'b0;
      center_aligned_select <= 1'b0;
      clks <= src_none;
      ps <= '0;
    end else if (clk_en && w_gsc) begin
      toie <= wd[ie_bit];
      center_aligned_select <= wd[mode_bit];
      clks <= clk_src_t'(wd[clks_lo +: 2]);
      ps <= wd[ps_width-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Clock source and prescaler
  // ---------------------------------------------------------------
  logic ext_rise, src_tick, tick;
  clk_sync_edge u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .async_in(ext_clk),
    .rise(ext_rise)
  );
  always_comb begin
    unique case (clks)
      src_none: src_tick = 1'b0;
      src_bus: src_tick = 1'b1;
      src_fixed: src_tick = fixed_clk_tick;
      src_ext: src_tick = ext_rise;
    endcase
  end
  tick_prescaler #(.width(pre_width)) u_pre (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .src_tick(src_tick && !debug_halt),
    .ps(ps),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  logic [15:0] cnt, mod, top, next_count;
  logic down, next_down, wrap;
  assign top = (mod == 16'h0000) ? free_top : mod;
  always_comb begin
    next_count = cnt;
    next_down = down;
    if (tick) begin
      if (!center_aligned_select) begin
        next_down = 1'b0;
        next_count = (cnt == mod && mod != 16'h0000) ? 16'h0000 : cnt + 16'h0001;
      end else if (!down) begin
        next_down = (cnt >= top);
        next_count = (cnt >= top) ? cnt - 16'h0001 : cnt + 16'h0001;
      end else begin
        next_down = (cnt != 16'h0000);
        next_count = (cnt == 16'h0000) ? cnt + 16'h0001 : cnt - 16'h0001;
      end
    end
  end
  assign wrap = tick && cnt != 16'h0000 && next_count == 16'h0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= cnt_reset;
      down <= 1'b0;
    end else if (clk_en) begin
      if (w_cnt) begin
        cnt <= cnt_reset;
        down <= 1'b0;
      end else if (tick) begin
        cnt <= next_count;
        down <= next_down;
      end
    end
  end

  // ---------------------------------------------------------------
  // Counter read latching
  // ---------------------------------------------------------------
  logic latched, first_hi;
  logic [15:0] hold, cnt_view;
  assign cnt_view = latched ? hold : cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latched <= 1'b0;
      first_hi <= 1'b0;
      hold <= cnt_reset;
    end else if (clk_en) begin
      if (w_gsc || w_cnt) begin
        latched <= 1'b0;
      end else if (!debug_halt && (r_cnth || r_cntl)) begin
        if (!latched) begin
          latched <= 1'b1;
          hold <= cnt;
          first_hi <= r_cnth;
        end else if (r_cnth != first_hi) begin
          latched <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Modulo buffering
  // ---------------------------------------------------------------
  logic got_hi, got_lo, mod_load, suppress;
  logic [15:0] mod_buf;
  assign suppress = got_hi ^ got_lo;
  always_comb begin
    mod_load = 1'b0;
    if (got_hi && got_lo) begin
      if (clks == src_none) begin
        mod_load = 1'b1;
      end else begin
        mod_load = tick && cnt == top - 16'h0001 && next_count == top;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      got_hi <= 1'b0;
      got_lo <= 1'b0;
      mod_buf <= mod_reset;
    end else if (clk_en) begin
      if (w_gsc || mod_load) begin
        got_hi <= 1'b0;
        got_lo <= 1'b0;
      end else if (!debug_halt) begin
        if (w_modh) begin
          got_hi <= 1'b1;
          mod_buf[15:8] <= wd;
        end
        if (w_modl) begin
          got_lo <= 1'b1;
          mod_buf[7:0] <= wd;
        end
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mod <= mod_reset;
    end else if (clk_en) begin
      if (debug_halt && w_modh) begin
        mod[15:8] <= wd;
      end else if (debug_halt && w_modl) begin
        mod[7:0] <= wd;
      end else if (mod_load) begin
        mod <= mod_buf;
      end
    end
  end

  // ---------------------------------------------------------------
  // Overflow flag
  // ---------------------------------------------------------------
  logic overflow_flag, tof_armed, tof_set;
  assign tof_set = wrap && !suppress;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_flag <= 1'b0;
      tof_armed <= 1'b0;
    end else if (clk_en) begin
      if (tof_set) begin
        overflow_flag <= 1'b1;
      end else if (w_gsc && tof_armed && !wd[flag_bit]) begin
        overflow_flag <= 1'b0;
      end
      if (tof_set || w_gsc) begin
        tof_armed <= 1'b0;
      end else if (r_gsc && overflow_flag) begin
        tof_armed <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Channel
  // ---------------------------------------------------------------
  logic chan_ie, msb, msa, cap_prev;
  logic [1:0] els;
  logic [15:0] cval;
  logic cap_mode, pwm_mode, extreme, cap_evt, cmp_evt, chan_set;
  logic chan_flag, chan_armed;
  assign cap_mode = !center_aligned_select && !msb && !msa && els != 2'b00;
  assign pwm_mode = center_aligned_select || msb;
  assign extreme = pwm_mode && (cval == 16'h0000 || cval > top);
  assign cap_evt = cap_mode && ((els[0] && capture_in && !cap_prev) || (els[1] && !capture_in && cap_prev));
  assign cmp_evt = !cap_mode && (pwm_mode || msa) && tick && next_count == cval && !extreme;
  assign chan_set = cap_evt || cmp_evt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_ie <= 1'b0;
      msb <= 1'b0;
      msa <= 1'b0;
      els <= 2'b00;
    end else if (clk_en && w_csc) begin
      chan_ie <= wd[ie_bit];
      msb <= wd[mode_bit];
      msa <= wd[msa_bit];
      els <= wd[els_lo +: 2];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cval <= cval_reset;
      cap_prev <= 1'b0;
    end else if (clk_en) begin
      cap_prev <= capture_in;
      if (cap_evt) begin
        cval <= cnt;
      end else if (w_cval && !cap_mode) begin
        cval <= hwdata[15:0];
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_flag <= 1'b0;
      chan_armed <= 1'b0;
    end else if (clk_en) begin
      if (chan_set) begin
        chan_flag <= 1'b1;
      end else if (w_csc && chan_armed && !wd[flag_bit]) begin
        chan_flag <= 1'b0;
      end
      if (chan_set || w_csc) begin
        chan_armed <= 1'b0;
      end else if (r_csc && chan_flag) begin
        chan_armed <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt lines and read data
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_irq <= 1'b0;
      channel_irq <= 1'b0;
    end else if (clk_en) begin
      overflow_irq <= overflow_flag && toie;
      channel_irq <= chan_flag && chan_ie;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (clk_en && state == st_data && !req.write) begin
      unique case (req.addr)
        off_gsc: hrdata <= {24'h000000, overflow_flag, toie, center_aligned_select, clks, ps};
        off_cnth: hrdata <= {24'h000000, cnt_view[15:8]};
        off_cntl: hrdata <= {24'h000000, cnt_view[7:0]};
        off_modh: hrdata <= {24'h000000, mod[15:8]};
        off_modl: hrdata <= {24'h000000, mod[7:0]};
        off_csc: hrdata <= {24'h000000, chan_flag, chan_ie, msb, msa, els, 2'b00};
        off_cval: hrdata <= {16'h0000, cval};
        default: hrdata <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_arm;
    clk_en && r_csc && chan_flag && !chan_set;
  endsequence
  sequence s_clear;
    clk_en && chan_armed && w_csc && !wd[flag_bit] && !chan_set;
  endsequence
  property p_chan_arm;
    @(posedge hclk) disable iff (!hresetn) s_arm |=> chan_armed ##1 1'b1;
  endproperty
  a_chan_arm: assert property (p_chan_arm) else $error("flag read did not arm clear");
  property p_chan_clear;
    @(posedge hclk) disable iff (!hresetn) s_clear |=> !chan_flag;
  endproperty
  a_chan_clear: assert property (p_chan_clear) else $error("flag clear sequence failed");
  property p_tof_wrap;
    @(posedge hclk) disable iff (!hresetn) clk_en && tof_set && !w_cnt |=> overflow_flag && cnt == 16'h0000;
  endproperty
  a_tof_wrap: assert property (p_tof_wrap) else $error("wrap did not set overflow");
  property p_cnt_clear;
    @(posedge hclk) disable iff (!hresetn) clk_en && w_cnt |=> cnt == 16'h0000 && !latched;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("counter write did not clear");
  property p_halt_freeze;
    @(posedge hclk) disable iff (!hresetn) clk_en && debug_halt && !w_cnt && !w_gsc |=> $stable(cnt) && $stable(latched);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("counter moved in halt");
  property p_no_src;
    @(posedge hclk) disable iff (!hresetn) clk_en && clks == src_none && !w_cnt |=> $stable(cnt);
  endproperty
  a_no_src: assert property (p_no_src) else $error("counter moved with no clock");
  property p_suppress;
    @(posedge hclk) disable iff (!hresetn) clk_en && got_hi != got_lo && !overflow_flag |=> !overflow_flag;
  endproperty
  a_suppress: assert property (p_suppress) else $error("overflow set during modulo write");
  property p_gsc_reset;
    @(posedge hclk) disable iff (!hresetn) clk_en && w_gsc |=> !got_hi && !got_lo && !latched;
  endproperty
  a_gsc_reset: assert property (p_gsc_reset) else $error("control write kept latches");
  property p_mod_direct;
    @(posedge hclk) disable iff (!hresetn) clk_en && debug_halt && w_modl && !w_modh |=> mod[7:0] == $past(wd);
  endproperty
  a_mod_direct: assert property (p_mod_direct) else $error("halt modulo write not direct");
  property p_irq;
    @(posedge hclk) disable iff (!hresetn) (clk_en && chan_flag && chan_ie)[*2] |-> channel_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("channel interrupt missing");
endmodule : pulse_timer_module

/* tb/testbench.sv */
// Self-checking testbench for the pulse timer module.
`timescale 1ns/1ps
module testbench;
  import pulse_timer_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, debug_halt = 1'b0, fixed_clk_tick = 1'b0, ext_clk = 1'b0, capture_in = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, overflow_irq, channel_irq, clk_en = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [15:0] v1, v2;
  logic [7:0] offs [6] = '{off_gsc, off_cnth, off_cntl, off_modh, off_modl, off_csc};
  int error_cnt = 0, comparisons = 0, e, ps, n;
  pulse_timer_module #(.pre_width(7)) dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .debug_halt(debug_halt),
    .fixed_clk_tick(fixed_clk_tick), .ext_clk(ext_clk), .capture_in(capture_in), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .overflow_irq(overflow_irq), .channel_irq(channel_irq));
  // ---------------------------------------------------------------
  // Clocks and bus tasks
  // ---------------------------------------------------------------
  always #25 hclk = ~hclk;
  always @(posedge hclk) fixed_clk_tick <= ~fixed_clk_tick;
  always begin
    repeat (2) @(posedge hclk);
    ext_clk <= ~ext_clk;
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= htrans_nonseq;
    haddr <= {24'h000000, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    rv = hrdata;
  endtask : bus
  task automatic rd_cnt(output logic [15:0] v);
    bus(1'b0, off_cntl, 32'h0);
    v[7:0] = rv[7:0];
    bus(1'b0, off_cnth, 32'h0);
    v[15:8] = rv[7:0];
  endtask : rd_cnt
  task automatic chk(input logic [31:0] g, input int lo, input int hi);
    comparisons++;
    if (((g >= lo) && (g <= hi)) !== 1'b1) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
    end
  endtask : chk
  function automatic int exp_cnt(input int src, input int p, input int cyc);
    exp_cnt = (src == 0) ? 0 : (src == 1) ? cyc >> p : (src == 2) ? (cyc / 2) >> p : (cyc / 4) >> p;
  endfunction : exp_cnt
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(27));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (offs[i]) begin
      bus(1'b0, offs[i], 32'h0);
      chk(rv, 0, 0);
      chk(hresp, 0, 0);
    end
    for (int s = 0; s < 4; s++) begin
      ps = $urandom % 4;
      n = 200 + $urandom % 300;
      bus(1'b1, off_gsc, 32'h0);
      bus(1'b1, off_cntl, 32'h5A);
      bus(1'b1, off_gsc, 32'(s * 8 + ps));
      repeat (n) @(posedge hclk);
      bus(1'b1, off_gsc, 32'h0);
      rd_cnt(v1);
      e = exp_cnt(s, ps, n);
      chk(v1, (e > 4) ? e - 4 : 0, e + 4);
    end
    bus(1'b1, off_cnth, 32'hA5);
    rd_cnt(v1);
    chk(v1, 0, 0);
    bus(1'b1, off_gsc, 32'h08);
    bus(1'b0, off_cnth, 32'h0);
    v1[15:8] = rv[7:0];
    repeat (300) @(posedge hclk);
    bus(1'b0, off_cntl, 32'h0);
    v1[7:0] = rv[7:0];
    rd_cnt(v2);
    chk(v2 - v1, 300, 320);
    debug_halt <= 1'b1;
    rd_cnt(v1);
    repeat (50) @(posedge hclk);
    rd_cnt(v2);
    chk(v2, v1, v1);
    bus(1'b1, off_modl, 32'h33);
    bus(1'b0, off_modl, 32'h0);
    chk(rv[7:0], 32'h33, 32'h33);
    debug_halt <= 1'b0;
    rd_cnt(v1);
    clk_en <= 1'b0;
    repeat (30) @(posedge hclk);
    clk_en <= 1'b1;
    rd_cnt(v2);
    chk(v2 - v1, 5, 8);
    bus(1'b1, off_gsc, 32'h0);
    bus(1'b1, off_modh, 32'h0);
    bus(1'b1, off_modl, 32'h40);
    bus(1'b0, off_modl, 32'h0);
    chk(rv[7:0], 32'h40, 32'h40);
    bus(1'b1, off_cntl, 32'h0);
    bus(1'b1, off_gsc, 32'h48);
    repeat (100) @(posedge hclk);
    bus(1'b1, off_gsc, 32'h40);
    bus(1'b0, off_gsc, 32'h0);
    chk(rv[7:0], 32'hC0, 32'hC0);
    chk(overflow_irq, 1, 1);
    rd_cnt(v1);
    chk(v1, 0, 32'h40);
    bus(1'b1, off_gsc, 32'h80);
    bus(1'b0, off_gsc, 32'h0);
    chk(rv[7:0], 32'h80, 32'h80);
    bus(1'b1, off_gsc, 32'h0);
    bus(1'b0, off_gsc, 32'h0);
    chk(rv[7:0], 32'h00, 32'h00);
    bus(1'b1, off_gsc, 32'h08);
    bus(1'b1, off_modh, 32'h0);
    repeat (150) @(posedge hclk);
    bus(1'b0, off_gsc, 32'h0);
    chk(rv[7], 0, 0);
    bus(1'b1, off_modl, 32'h40);
    repeat (150) @(posedge hclk);
    bus(1'b0, off_gsc, 32'h0);
    chk(rv[7], 1, 1);
    bus(1'b1, off_gsc, 32'h0);
    bus(1'b1, off_modh, 32'h0);
    bus(1'b1, off_modl, 32'h0);
    bus(1'b1, off_cntl, 32'h0);
    bus(1'b1, off_cval, 32'h20);
    bus(1'b1, off_csc, 32'h50);
    bus(1'b1, off_gsc, 32'h08);
    repeat (40) @(posedge hclk);
    bus(1'b0, off_csc, 32'h0);
    chk(rv[7:0], 32'hD0, 32'hD0);
    chk(channel_irq, 1, 1);
    bus(1'b1, off_csc, 32'h10);
    bus(1'b0, off_csc, 32'h0);
    chk(rv[7:0], 32'h10, 32'h10);
    chk(channel_irq, 0, 0);
    bus(1'b1, off_csc, 32'h44);
    capture_in <= 1'b1;
    repeat (5) @(posedge hclk);
    bus(1'b0, off_csc, 32'h0);
    chk(rv[7:0], 32'hC4, 32'hC4);
    bus(1'b1, off_gsc, 32'h0);
    bus(1'b1, off_cntl, 32'h0);
    bus(1'b1, off_modh, 32'h0);
    bus(1'b1, off_modl, 32'h10);
    bus(1'b1, off_csc, 32'h20);
    bus(1'b1, off_cval, 32'h0);
    bus(1'b1, off_gsc, 32'h08);
    repeat (60) @(posedge hclk);
    bus(1'b0, off_csc, 32'h0);
    chk(rv[7:0], 32'h20, 32'h20);
    bus(1'b1, off_cval, 32'h08);
    repeat (40) @(posedge hclk);
    bus(1'b1, off_gsc, 32'h0);
    bus(1'b0, off_csc, 32'h0);
    chk(rv[7:0], 32'hA0, 32'hA0);
    bus(1'b1, off_cntl, 32'h0);
    bus(1'b1, off_gsc, 32'h28);
    repeat (17) @(posedge hclk);
    bus(1'b1, off_gsc, 32'h0);
    rd_cnt(v1);
    chk(v1, 32'h0A, 32'h0E);
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    report_and_stop();
  end
endmodule : testbench
